// [src/pmcs_consts.svh]
// Constants of the power mode and clock select block.
// Assumes a 125 MHz system clock and a plain byte-wide register port.
//Contract
// - Sleep bit set puts device in sleep and stops sampling.
// - Cycle set, sleep clear: sleep and wake for single samples at wake rate.
// - Clock field: 0 internal, 1-3 gyro PLL, 4 ext 32.768 kHz, 5 ext 19.2 MHz.
// - Clock code 7 stops clock and holds timing generator in reset.
// - After power-up the device runs from the internal oscillator.
// - Gyro-less low power allowed only with internal or external clock.
// - Full-chip reset bit restores all registers, then clears itself.
// - Thermal-sensor disable bit switches the temperature sensor off.
// - Wake rate codes 0..3 give 1.25, 5, 20, 40 Hz.
// - Accel-only mode powers down all but host interface, waking accel only.
// - Six standby bits 5..0 place each accel and gyro axis in standby.
// - Standby of the gyro axis used as PLL reference forces internal clock.
// - Control one: reset 7, sleep 6, cycle 5, thermal 3, clock 2..0.
`ifndef PMCS_CONSTS_SVH
`define PMCS_CONSTS_SVH
`define PMCS_ADDR_W         8
`define PMCS_OFF_CTRL_ONE   8'h6B
`define PMCS_OFF_CTRL_TWO   8'h6C
`define PMCS_RST_CTRL_ONE   8'h00
`define PMCS_RST_CTRL_TWO   8'h00
`define PMCS_BIT_RESET      7
`define PMCS_BIT_SLEEP      6
`define PMCS_BIT_CYCLE      5
`define PMCS_BIT_THERM      3
`define PMCS_CLK_RESERVED   3'h6
`define PMCS_CLK_STOP       3'h7
`define PMCS_CTRL_ONE_MASK  8'hEF
`define PMCS_CLK_HZ         125000000
// Wake rates in centihertz so 1.25 Hz stays an integer
`define PMCS_WAKE_CHZ_0     125
`define PMCS_WAKE_CHZ_1     500
`define PMCS_WAKE_CHZ_2     2000
`define PMCS_WAKE_CHZ_3     4000
`define PMCS_SAMPLE_NS      1000
`define PMCS_SAMPLE_CYC     ((`PMCS_SAMPLE_NS * (`PMCS_CLK_HZ / 1000000) + 999) / 1000)
`define PMCS_RESET_CYC      4
`endif

// [src/pmcs_pkg.sv]
// Types of the power mode and clock select block.
// Used by the design module, its checker and the bench.
package pmcs_pkg;
  typedef enum logic [2:0] {
    PMCS_CLK_INT     = 3'h0,
    PMCS_CLK_GYRO_X  = 3'h1,
    PMCS_CLK_GYRO_Y  = 3'h2,
    PMCS_CLK_GYRO_Z  = 3'h3,
    PMCS_CLK_EXT_LO  = 3'h4,
    PMCS_CLK_EXT_HI  = 3'h5,
    PMCS_CLK_RSVD    = 3'h6,
    PMCS_CLK_STOPPED = 3'h7
  } pmcs_clk_e;

  typedef enum logic [3:0] {
    PMCS_ST_RUN   = 4'h1,
    PMCS_ST_SLEEP = 4'h2,
    PMCS_ST_WAIT  = 4'h4,
    PMCS_ST_WAKE  = 4'h8
  } pmcs_state_e;

  typedef struct packed {
    logic [1:0] wake_rate;
    logic       accel_x;
    logic       accel_y;
    logic       accel_z;
    logic       gyro_x;
    logic       gyro_y;
    logic       gyro_z;
  } pmcs_two_s;

  typedef struct packed {
    logic       sensors_on;
    logic       sample_pulse;
    logic [2:0] accel_on;
    logic [2:0] gyro_on;
    logic       temp_on;
    logic       timing_reset;
    logic       dev_clk_run;
    logic [2:0] clk_source;
    logic       accel_only_lp;
  } pmcs_ctl_s;
endpackage

// [src/pmcs_power_ctrl.sv]
// Power mode, standby, full-chip reset and clock source control.
// Assumes synchronous byte register port; reads answer one cycle later.
`timescale 1ns/100ps
`include "pmcs_consts.svh"
module pmcs_power_ctrl #(
  parameter int unsigned CLK_HZ     = `PMCS_CLK_HZ,
  parameter int unsigned SAMPLE_CYC = `PMCS_SAMPLE_CYC,
  parameter int unsigned RESET_CYC  = `PMCS_RESET_CYC,
  parameter int unsigned WAKE_DIV   = 1
) (
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  input  wire logic [`PMCS_ADDR_W-1:0]     addr_i,
  input  wire logic [7:0]                  wdata_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  output logic      [7:0]                  rdata_o,
  output pmcs_pkg::pmcs_ctl_s              ctl_o,
  output logic                             chip_reset_o
);
  import pmcs_pkg::*;

  // Refuse parameter sets the counters cannot serve
  if (SAMPLE_CYC < 1 || RESET_CYC < 1 || WAKE_DIV < 1 || CLK_HZ < 100)
  begin : g_bad_param
    $error("pmcs_power_ctrl: bad parameter");
  end

  // Wake period in cycles; WAKE_DIV shortens it for simulation
  function automatic logic [31:0] wake_cycles(input logic [1:0] code);
    longint unsigned chz;
    chz = (code == 2'h0) ? `PMCS_WAKE_CHZ_0 :
          (code == 2'h1) ? `PMCS_WAKE_CHZ_1 :
          (code == 2'h2) ? `PMCS_WAKE_CHZ_2 : `PMCS_WAKE_CHZ_3;
    wake_cycles = 32'((longint'(CLK_HZ) * 100) / chz / WAKE_DIV);
  endfunction

  logic [7:0]  one_q;
  pmcs_two_s   two_q;
  logic [7:0]  rdata_q;
  logic [31:0] rst_cnt_q;
  logic [31:0] wake_cnt_q;
  logic [31:0] samp_cnt_q;
  pmcs_state_e st_q;
  pmcs_state_e st_d;

  wire sel_one = (addr_i == `PMCS_OFF_CTRL_ONE);
  wire sel_two = (addr_i == `PMCS_OFF_CTRL_TWO);
  wire resetting = (rst_cnt_q != 32'h0);
  wire wr_one = wr_i && sel_one && !resetting;
  wire wr_two = wr_i && sel_two && !resetting;

  wire [2:0] wr_clk = wdata_i[2:0];
  // Reserved code keeps the old source
  wire [2:0] clk_wr_d = (wr_clk == `PMCS_CLK_RESERVED) ? one_q[2:0] : wr_clk;
  wire [7:0] one_wr =
    {1'b0, wdata_i[6:5], 1'b0, wdata_i[`PMCS_BIT_THERM], clk_wr_d} & `PMCS_CTRL_ONE_MASK;
  wire [7:0] one_base = wr_one ? one_wr : one_q;
  pmcs_two_s two_base;
  assign two_base = wr_two ? pmcs_two_s'(wdata_i) : two_q;

  // Fallback when the referenced gyro axis enters standby
  wire [2:0] gsby = {two_base.gyro_x, two_base.gyro_y, two_base.gyro_z};
  wire gyro_ref_lost =
    (one_base[2:0] == PMCS_CLK_GYRO_X && gsby[2]) ||
    (one_base[2:0] == PMCS_CLK_GYRO_Y && gsby[1]) ||
    (one_base[2:0] == PMCS_CLK_GYRO_Z && gsby[0]);
  wire [7:0] one_d = gyro_ref_lost ? {one_base[7:3], PMCS_CLK_INT} : one_base;

  wire chip_rst_req = wr_one && wdata_i[`PMCS_BIT_RESET];

  // Register file with self-clearing full-chip reset
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      one_q     <= `PMCS_RST_CTRL_ONE;
      two_q     <= pmcs_two_s'(`PMCS_RST_CTRL_TWO);
      rst_cnt_q <= 32'h0;
    end
    else if (chip_rst_req)
    begin
      one_q     <= `PMCS_RST_CTRL_ONE | 8'h80;
      two_q     <= pmcs_two_s'(`PMCS_RST_CTRL_TWO);
      rst_cnt_q <= 32'(RESET_CYC);
    end
    else if (resetting)
    begin
      rst_cnt_q <= rst_cnt_q - 32'h1;
      one_q     <= (rst_cnt_q == 32'h1) ? `PMCS_RST_CTRL_ONE : one_q;
    end
    else
    begin
      one_q <= one_d;
      two_q <= two_base;
    end
  end

  // Read port, data valid one cycle after the strobe
  wire [7:0] rd_mux = sel_one ? (one_q & `PMCS_CTRL_ONE_MASK) :
                      sel_two ? 8'(two_q) : 8'h00;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_q <= 8'h00;
    else
      rdata_q <= rd_i ? rd_mux : 8'h00;
  end
  assign rdata_o = rdata_q;

  // Power state machine
  wire sleep_b = one_q[`PMCS_BIT_SLEEP];
  wire cycle_b = one_q[`PMCS_BIT_CYCLE];
  wire stop_clk = (one_q[2:0] == `PMCS_CLK_STOP);
  wire wake_tick = (wake_cnt_q == 32'h0);
  wire samp_done = (samp_cnt_q == 32'h0);

  always_comb
  begin
    st_d = st_q;
    case (st_q)
      PMCS_ST_RUN:
        if (sleep_b) st_d = PMCS_ST_SLEEP;
        else if (cycle_b) st_d = PMCS_ST_WAIT;
      PMCS_ST_SLEEP:
        if (!sleep_b) st_d = cycle_b ? PMCS_ST_WAIT : PMCS_ST_RUN;
      PMCS_ST_WAIT:
        if (sleep_b) st_d = PMCS_ST_SLEEP;
        else if (!cycle_b) st_d = PMCS_ST_RUN;
        else if (wake_tick) st_d = PMCS_ST_WAKE;
      PMCS_ST_WAKE:
        if (sleep_b) st_d = PMCS_ST_SLEEP;
        else if (samp_done) st_d = cycle_b ? PMCS_ST_WAIT : PMCS_ST_RUN;
      default:
        st_d = PMCS_ST_RUN;
    endcase
  end

  // Timing generator is held in reset while the clock is stopped
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_q       <= PMCS_ST_RUN;
      wake_cnt_q <= 32'h0;
      samp_cnt_q <= 32'h0;
    end
    else if (stop_clk || resetting)
    begin
      st_q       <= PMCS_ST_RUN;
      wake_cnt_q <= 32'h0;
      samp_cnt_q <= 32'h0;
    end
    else
    begin
      st_q       <= st_d;
      wake_cnt_q <= (st_q != PMCS_ST_WAIT || wake_tick) ?
                    wake_cycles(two_q.wake_rate) - 32'h1 : wake_cnt_q - 32'h1;
      samp_cnt_q <= (st_q != PMCS_ST_WAKE) ? 32'(SAMPLE_CYC) - 32'h1 :
                    (samp_done ? 32'h0 : samp_cnt_q - 32'h1);
    end
  end

  // Gyro-less low power only with internal or external clock
  wire clk_lp_ok = (one_q[2:0] == PMCS_CLK_INT) || (one_q[2:0] == PMCS_CLK_EXT_LO) ||
                   (one_q[2:0] == PMCS_CLK_EXT_HI);
  wire gyros_off = two_q.gyro_x && two_q.gyro_y && two_q.gyro_z;
  wire accel_only = cycle_b && !sleep_b && one_q[`PMCS_BIT_THERM] && gyros_off &&
                    clk_lp_ok;
  wire awake = !stop_clk && !resetting &&
               (st_q == PMCS_ST_RUN || st_q == PMCS_ST_WAKE);
  wire [2:0] acc_sby = {two_q.accel_x, two_q.accel_y, two_q.accel_z};
  wire [2:0] gyr_sby = {two_q.gyro_x, two_q.gyro_y, two_q.gyro_z};

  pmcs_ctl_s ctl_q;
  pmcs_ctl_s ctl_d;
  always_comb
  begin
    ctl_d               = '0;
    ctl_d.sensors_on    = awake;
    ctl_d.sample_pulse  = (st_q == PMCS_ST_WAKE) && samp_done && !stop_clk;
    ctl_d.accel_on      = awake ? ~acc_sby : 3'h0;
    ctl_d.gyro_on       = (awake && !accel_only) ? ~gyr_sby : 3'h0;
    ctl_d.temp_on       = awake && !one_q[`PMCS_BIT_THERM] && !accel_only;
    ctl_d.timing_reset  = stop_clk || resetting;
    ctl_d.dev_clk_run   = !stop_clk;
    ctl_d.clk_source    = one_q[2:0];
    ctl_d.accel_only_lp = accel_only;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ctl_q        <= '0;
      chip_reset_o <= 1'b0;
    end
    else
    begin
      ctl_q        <= ctl_d;
      chip_reset_o <= chip_rst_req || (resetting && rst_cnt_q != 32'h1);
    end
  end
  assign ctl_o = ctl_q;
endmodule // pmcs_power_ctrl

// [bench/pmcs_power_ctrl_monitor.sv]
// Checker for the power mode and clock select block.
// Sees only the top module ports; bound below its endmodule.
`timescale 1ns/100ps
module pmcs_power_ctrl_chk #(
  parameter int unsigned RESET_CYC = 4
) (
  input wire logic                clk_i,
  input wire logic                rst_n_i,
  input wire logic [7:0]          addr_i,
  input wire logic [7:0]          wdata_i,
  input wire logic                wr_i,
  input wire logic                rd_i,
  input wire logic [7:0]          rdata_o,
  input wire pmcs_pkg::pmcs_ctl_s ctl_o,
  input wire logic                chip_reset_o
);
  import pmcs_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [7:0] run_q;
  wire wr_one = wr_i && (addr_i == 8'h6B) && !chip_reset_o;
  wire wr_two = wr_i && (addr_i == 8'h6C) && !chip_reset_o;
  // Length of the chip reset pulse, compared when it falls
  always_ff @(posedge clk_i or negedge rst_n_i)
    if (!rst_n_i) run_q <= 8'h00;
    else run_q <= chip_reset_o ? run_q + 8'h01 : 8'h00;
  AST_SLEEP: assert property (wr_one && wdata_i[6] && !wdata_i[7]
    |-> ##[1:3] !ctl_o.sensors_on) else $error("sleep write left sensors on");
  AST_TEMP: assert property (wr_one && wdata_i[3] && !wdata_i[7]
    |-> ##[1:3] !ctl_o.temp_on) else $error("temp sensor stayed on");
  AST_STOP: assert property (ctl_o.clk_source == 3'h7
    |-> !ctl_o.dev_clk_run && ctl_o.timing_reset) else $error("stop code clock ran");
  AST_NO_RSVD: assert property (ctl_o.clk_source != 3'h6)
    else $error("reserved clock code taken");
  AST_STBY: assert property (wr_two
    |-> ##3 ({ctl_o.accel_on, ctl_o.gyro_on} & $past(wdata_i[5:0], 3)) == 6'h00)
    else $error("standby axis still on");
  AST_FALLBACK: assert property (wr_two && wdata_i[2] && ctl_o.clk_source == 3'h1
    |-> ##[1:3] ctl_o.clk_source == 3'h0) else $error("no fallback to internal clock");
  AST_TRIG: assert property (wr_one && wdata_i[7] |-> ##1 chip_reset_o)
    else $error("chip reset not started");
  AST_LEN: assert property ($fell(chip_reset_o) |-> run_q == RESET_CYC)
    else $error("chip reset pulse length wrong");
  AST_RSVD: assert property ($past(rd_i) && $past(addr_i) == 8'h6B |-> !rdata_o[4])
    else $error("reserved bit read as one");
  AST_LP: assert property (ctl_o.accel_only_lp |-> ctl_o.gyro_on == 3'h0
    && !ctl_o.temp_on && ctl_o.clk_source inside {3'h0, 3'h4, 3'h5})
    else $error("low power mode state wrong");
endmodule // pmcs_power_ctrl_chk
bind pmcs_power_ctrl pmcs_power_ctrl_chk #(.RESET_CYC(RESET_CYC)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .ctl_o(ctl_o), .chip_reset_o(chip_reset_o));

// [bench/power_mode_clock_select_tb_top.sv]
// Self-checking bench for the power mode and clock select block.
// Drives the register port itself; wake periods shortened by WAKE_DIV.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); fails++; end end
module power_mode_clock_select_tb_top;
  import pmcs_pkg::*;
  localparam int DIV = 10000;
  localparam int SCYC = 125;
  logic       clk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic       wr_i = 1'b0;
  logic       rd_i = 1'b0;
  logic [7:0] rdata_o;
  pmcs_ctl_s  ctl_o;
  logic       chip_reset_o;
  int         fails = 0;
  int         checks_done = 0;
  pmcs_power_ctrl #(.SAMPLE_CYC(SCYC), .WAKE_DIV(DIV)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .ctl_o(ctl_o), .chip_reset_o(chip_reset_o));
  initial forever #4 clk_i = ~clk_i;
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 `CHK(n, e, rdata_o)
  endtask
  // Output struct lags the registers, so let it settle
  task automatic st;
    repeat (3) @(posedge clk_i);
    #1;
  endtask
  task automatic t_clk;
    logic [2:0] e;
    e = 3'h0;
    `CHK("clk_rst", 3'h0, ctl_o.clk_source)
    rd(8'h6C, 8'h00, "two_rst");
    rd(8'h6A, 8'h00, "unmapped");
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h6B, 8'h10 | 8'(c));
      if (c != 6) e = 3'(c);
      rd(8'h6B, {5'h00, e}, "clk_code");
      st();
      `CHK("clk_out", e, ctl_o.clk_source)
      `CHK("clk_run", (e != 3'h7), ctl_o.dev_clk_run)
      `CHK("tg_rst", (e == 3'h7), ctl_o.timing_reset)
    end
    $display("t_clk done");
  endtask
  task automatic t_sleep;
    wr(8'h6B, 8'h40);
    rd(8'h6B, 8'h40, "sleep_rd");
    st();
    `CHK("asleep", 1'b0, ctl_o.sensors_on)
    wr(8'h6B, 8'h08);
    st();
    `CHK("awake", 1'b1, ctl_o.sensors_on)
    `CHK("temp_off", 1'b0, ctl_o.temp_on)
    $display("t_sleep done");
  endtask
  task automatic t_stby;
    wr(8'h6B, 8'h02);
    wr(8'h6C, 8'h22);
    rd(8'h6B, 8'h00, "fallback");
    st();
    `CHK("accel", 3'b011, ctl_o.accel_on)
    `CHK("gyro", 3'b101, ctl_o.gyro_on)
    wr(8'h6B, 8'h01);
    st();
    `CHK("clk_gx", 3'h1, ctl_o.clk_source)
    // Standby of the X gyro while it is the reference must drop to internal
    wr(8'h6C, 8'h04);
    rd(8'h6B, 8'h00, "fallback_x");
    st();
    `CHK("clk_fb", 3'h0, ctl_o.clk_source)
    `CHK("gyro_x", 3'b011, ctl_o.gyro_on)
    $display("t_stby done");
  endtask
  task automatic t_lp;
    int chz[4] = '{125, 500, 2000, 4000};
    int n;
    int p;
    wr(8'h6B, 8'h20);
    wr(8'h6B, 8'h28);
    for (int r = 0; r < 4; r++)
    begin
      wr(8'h6C, {2'(r), 6'h07});
      st();
      `CHK("lp", 1'b1, ctl_o.accel_only_lp)
      p = 125000000 / chz[r] * 100 / DIV;
      // Second interval only: the first one straddles the rate change
      for (int k = 0; k < 2; k++)
      begin
        n = 0;
        do
        begin
          @(posedge clk_i);
          #1 n++;
        end
        while (ctl_o.sample_pulse !== 1'b1 && n < 30000);
        if (n >= 30000) begin fails++; print_verdict(); end
      end
      `CHK("wake", 1'b1, (n >= p && n <= p + SCYC + 2))
    end
    $display("t_lp done");
  endtask
  task automatic t_chip;
    wr(8'h6C, 8'h3F);
    wr(8'h6B, 8'h80);
    #1 `CHK("rst_pulse", 1'b1, chip_reset_o)
    wr(8'h6C, 8'h01);
    rd(8'h6B, 8'h80, "one_busy");
    repeat (8) @(posedge clk_i);
    rd(8'h6B, 8'h00, "one_clr");
    rd(8'h6C, 8'h00, "two_clr");
    $display("t_chip done");
  endtask
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_clk();
    t_sleep();
    t_stby();
    t_lp();
    t_chip();
    print_verdict();
  end
endmodule // power_mode_clock_select_tb_top
